//--- rtl/axis_enable_fault_interlock.sv
// axis drive enable and fault interlock with an AHB-Lite register port
// assumes one hclk domain; amplifier ready and stop inputs are asynchronous pins
//
// How it works
// - A missed or lost amplifier ready halts the axis and reports error code C0h.
// - Moves other than jog and local logic start run only while the drive enable bit is held at 1.
// - While configured and without a halting fault the drive-on status follows the drive enable bit.
// - A halting fault forces drive-on to 0 even with drive enable still at 1.
// - After the cause is gone, a fault clear from the host restores drive enabling.
// - When halted, error reads 1, axis-active and drive-on read 0, and the LED flashes fast.
// - When halted, only the fault clear bit is acted upon.
// - The fault clear bit acts only on its 0-to-1 change between sweeps.
// - Host commands are ignored and the config LED stays off until a valid config arrives.
// - Configuration faults show as a system-class code in the error word.
// - Home, program or local logic start bits on the first sweep are rejected with an error.
// - Velocity or position move words on the first sweep are rejected with an error.
`timescale 1ns/1ps
module axis_enable_fault_interlock
  import axis_interlock_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P   = TICK_CYCLES,
  parameter int unsigned READY_TIMEOUT_P = READY_TIMEOUT_TICKS,
  parameter int unsigned FLASH_TICKS_P   = FAST_FLASH_TICKS
)(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic                      amp_ready_n,
  input  wire logic                      stop_fault,
  output logic                           drive_relay,
  output logic                           status_led,
  output logic                           cfg_ok_led,
  output logic                           jog_fwd,
  output logic                           jog_rev,
  output logic                           home_start,
  output logic                           program_start,
  output logic                           local_logic_start,
  output logic                           velocity_move_start,
  output logic                           position_move_start,
  output logic [CMD_OPER_WIDTH-1:0]      move_operand,
  output logic                           irq
);

  localparam int RCW = $clog2(READY_TIMEOUT_P + 2);
  localparam int FCW = $clog2(FLASH_TICKS_P + 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                      ready_s1;
    logic                      ready_s2;
    logic                      stop_s1;
    logic                      stop_s2;
    logic                      ah_valid;
    logic                      ah_write;
    logic [7:0]                ah_addr;
    logic                      rd_wait;
    logic [31:0]               hrdata;
    logic [CTL_WIDTH-1:0]      ctl_shadow;
    logic [CTL_WIDTH-1:0]      ctl_now;
    logic [31:0]               cmd_shadow;
    logic [31:0]               cmd_now;
    logic                      first_pending;
    logic                      cfg_ok;
    logic                      ready_en;
    axis_state_e               axis_state;
    logic                      warn;
    logic [15:0]               axis_err;
    logic [15:0]               sys_err;
    logic                      ready_seen;
    logic [RCW-1:0]            ready_count;
    logic [FCW-1:0]            flash_count;
    logic                      flash;
    logic                      home_go;
    logic                      prog_go;
    logic                      local_go;
    logic                      vel_go;
    logic                      pos_go;
    logic [CMD_OPER_WIDTH-1:0] operand;
    logic [INT_WIDTH-1:0]      int_status;
    logic [INT_WIDTH-1:0]      int_enable;
  } state_s;

  state_s r;
  state_s n;
  logic   tick;
  logic   drive_on;
  logic   axis_active;

  tick_divider #(
    .CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  function automatic logic is_move(input logic [31:0] word);
    is_move = (word[CMD_TYPE_WIDTH-1:0] == CMD_VELOCITY) ||
              (word[CMD_TYPE_WIDTH-1:0] == CMD_POSITION);
  endfunction

  // drive follows the sampled enable bit only while running without fault
  assign axis_active = (r.axis_state == ST_READY);
  assign drive_on    = axis_active & r.ctl_now[CTL_DRIVE_EN_BIT];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0]           rd_data;
    logic [31:0]           status_word;
    logic [CTL_WIDTH-1:0]  ctl_rise;
    logic [INT_WIDTH-1:0]  int_set;
    logic [INT_WIDTH-1:0]  int_clr;
    logic                  wr_en;
    logic                  sweep;
    logic                  cfg_wr;
    logic                  amp_ok;
    logic                  stop_now;
    logic                  cmd_new;
    logic                  motion_ok;
    logic                  start_req;
    logic                  ready_fail;
    rd_data     = '0;
    wr_en       = 1'b0;
    amp_ok      = 1'b0;
    stop_now    = 1'b0;
    status_word = '0;
    ctl_rise    = '0;
    int_set     = '0;
    int_clr     = '0;
    sweep       = 1'b0;
    cfg_wr      = 1'b0;
    cmd_new     = 1'b0;
    motion_ok   = 1'b0;
    start_req   = 1'b0;
    ready_fail  = 1'b0;
    n           = r;
    n.home_go   = 1'b0;
    n.prog_go   = 1'b0;
    n.local_go  = 1'b0;
    n.vel_go    = 1'b0;
    n.pos_go    = 1'b0;

    // pin synchronisers
    n.ready_s1 = amp_ready_n;
    n.ready_s2 = r.ready_s1;
    n.stop_s1  = stop_fault;
    n.stop_s2  = r.stop_s1;
    amp_ok     = ~r.ready_s2;
    stop_now   = r.stop_s2;

    // ---------------------------------------------------------------
    // register read mux
    // ---------------------------------------------------------------
    status_word[ST_ERROR_BIT]    = (r.axis_state == ST_FAULT) | r.warn;
    status_word[ST_ACTIVE_BIT]   = axis_active;
    status_word[ST_DRIVE_ON_BIT] = drive_on;
    status_word[ST_CFG_OK_BIT]   = r.cfg_ok;
    status_word[ST_FIRST_BIT]    = r.first_pending;
    status_word[ST_AMP_OK_BIT]   = amp_ok;
    status_word[ST_JOG_ONLY_BIT] = axis_active & ~drive_on;
    case (r.ah_addr)
      CONTROL_OFFSET:    rd_data = 32'(r.ctl_shadow);
      COMMAND_OFFSET:    rd_data = r.cmd_shadow;
      CONFIG_OFFSET:     rd_data = 32'(r.ready_en);
      STATUS_OFFSET:     rd_data = status_word;
      ERROR_OFFSET:      rd_data = {r.sys_err, r.axis_err};
      INT_STATUS_OFFSET: rd_data = 32'(r.int_status);
      INT_ENABLE_OFFSET: rd_data = 32'(r.int_enable);
      default:           rd_data = '0;
    endcase

    // ---------------------------------------------------------------
    // bus slave: writes take no wait, reads take one
    // ---------------------------------------------------------------
    wr_en = r.ah_valid & r.ah_write;
    if (r.ah_valid & ~r.ah_write & ~r.rd_wait) begin
      n.rd_wait = 1'b1;
      n.hrdata  = rd_data;
    end else begin
      n.rd_wait  = 1'b0;
      n.ah_valid = hsel & htrans[1] & hready;
      n.ah_write = hwrite;
      n.ah_addr  = haddr[7:0];
    end
    if (wr_en) begin
      case (r.ah_addr)
        CONTROL_OFFSET:    n.ctl_shadow = hwdata[CTL_WIDTH-1:0];
        COMMAND_OFFSET:    n.cmd_shadow = hwdata;
        SWEEP_OFFSET:      sweep = 1'b1;
        CONFIG_OFFSET:     cfg_wr = 1'b1;
        INT_ENABLE_OFFSET: n.int_enable = hwdata[INT_WIDTH-1:0];
        INT_CLEAR_OFFSET:  int_clr = hwdata[INT_WIDTH-1:0];
        default:           ;
      endcase
    end

    // ---------------------------------------------------------------
    // configuration commit
    // ---------------------------------------------------------------
    if (cfg_wr & hwdata[CFG_COMMIT_BIT]) begin
      if ((hwdata & CFG_RSVD_MASK) != '0) begin
        n.cfg_ok     = 1'b0;
        n.sys_err    = SYS_ERR_CONFIG;
        n.axis_state = ST_UNCONFIG;
        int_set[INT_CFG_ERR] = 1'b1;
      end else begin
        n.cfg_ok   = 1'b1;
        n.ready_en = hwdata[CFG_READY_EN_BIT];
        n.sys_err  = ERR_NONE;
        if (r.axis_state == ST_UNCONFIG) begin
          n.axis_state = ST_READY;
        end
      end
    end

    // ---------------------------------------------------------------
    // sweep exchange: sample host bits and act on edges
    // ---------------------------------------------------------------
    if (sweep) begin
      ctl_rise        = r.ctl_shadow & ~r.ctl_now;
      cmd_new         = (r.cmd_shadow != r.cmd_now);
      n.ctl_now       = r.ctl_shadow;
      n.cmd_now       = r.cmd_shadow;
      n.first_pending = 1'b0;
      int_set[INT_SWEEP] = 1'b1;
      motion_ok = r.ctl_shadow[CTL_DRIVE_EN_BIT];
      start_req = ctl_rise[CTL_HOME_BIT] | ctl_rise[CTL_PROGRAM_BIT] |
                  ctl_rise[CTL_LOCAL_BIT] | (cmd_new & is_move(r.cmd_shadow));
      case (r.axis_state)
        ST_FAULT: begin
          // everything but a clear edge is dropped while halted
          if (ctl_rise[CTL_CLEAR_BIT] & ~stop_now) begin
            n.axis_state = ST_READY;
            n.axis_err   = ERR_NONE;
            n.warn       = 1'b0;
          end
        end
        ST_READY: begin
          if (ctl_rise[CTL_CLEAR_BIT]) begin
            n.warn     = 1'b0;
            n.axis_err = ERR_NONE;
          end
          if (r.first_pending) begin
            if (start_req) begin
              n.warn   = 1'b1;
              n.axis_err = ERR_FIRST_SWEEP;
              int_set[INT_REJECT] = 1'b1;
            end
          end else begin
            n.home_go  = ctl_rise[CTL_HOME_BIT] & motion_ok;
            n.prog_go  = ctl_rise[CTL_PROGRAM_BIT] & motion_ok;
            n.local_go = ctl_rise[CTL_LOCAL_BIT];
            if (cmd_new & motion_ok) begin
              n.vel_go  = r.cmd_shadow[CMD_TYPE_WIDTH-1:0] == CMD_VELOCITY;
              n.pos_go  = r.cmd_shadow[CMD_TYPE_WIDTH-1:0] == CMD_POSITION;
              if (is_move(r.cmd_shadow)) begin
                n.operand = r.cmd_shadow[CMD_OPER_LSB +: CMD_OPER_WIDTH];
              end
            end
          end
        end
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // amplifier ready supervision, counted in millisecond ticks
    // ---------------------------------------------------------------
    if (~drive_on | ~r.ready_en) begin
      n.ready_count = '0;
      n.ready_seen  = 1'b0;
    end else begin
      if (amp_ok) begin
        n.ready_seen = 1'b1;
      end else if (r.ready_seen || r.ready_count > RCW'(READY_TIMEOUT_P)) begin
        ready_fail = 1'b1;
      end
      if (tick && r.ready_count <= RCW'(READY_TIMEOUT_P)) begin
        n.ready_count = r.ready_count + 1'b1;
      end
    end

    // halting faults override a clear in the same cycle
    if ((ready_fail | stop_now) & (n.axis_state == ST_READY)) begin
      n.axis_state = ST_FAULT;
      n.axis_err   = ready_fail ? ERR_DRIVE_READY : ERR_STOP_INPUT;
      int_set[INT_FAULT] = 1'b1;
    end

    // ---------------------------------------------------------------
    // fast flash and interrupts
    // ---------------------------------------------------------------
    if (tick) begin
      if (r.flash_count >= FCW'(FLASH_TICKS_P - 1)) begin
        n.flash_count = '0;
        n.flash       = ~r.flash;
      end else begin
        n.flash_count = r.flash_count + 1'b1;
      end
    end
    n.int_status = (r.int_status & ~int_clr) | int_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r               <= '0;
      r.ready_s1      <= 1'b1;
      r.ready_s2      <= 1'b1;
      r.first_pending <= 1'b1;
      r.axis_state    <= ST_UNCONFIG;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout           = ~(r.ah_valid & ~r.ah_write & ~r.rd_wait);
  assign hresp               = 1'b0;
  assign hrdata              = r.hrdata;
  assign drive_relay         = drive_on;
  assign status_led          = (r.axis_state == ST_FAULT) ? r.flash : axis_active;
  assign cfg_ok_led          = r.cfg_ok;
  assign jog_fwd             = axis_active & r.ctl_now[CTL_JOG_FWD_BIT];
  assign jog_rev             = axis_active & r.ctl_now[CTL_JOG_REV_BIT];
  assign home_start          = r.home_go;
  assign program_start       = r.prog_go;
  assign local_logic_start   = r.local_go;
  assign velocity_move_start = r.vel_go;
  assign position_move_start = r.pos_go;
  assign move_operand        = r.operand;
  assign irq                 = |(r.int_status & r.int_enable);

endmodule

//--- rtl/axis_interlock_pkg.sv
// constants, register map and types for the axis enable and fault interlock
// assumes a 25 MHz hclk and a 32-bit AHB-Lite register port
package axis_interlock_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ              = 25_000_000;
  localparam int unsigned TICK_US             = 1000;
  localparam int unsigned TICK_CYCLES         = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned READY_TIMEOUT_MS    = 1000;
  localparam int unsigned READY_TIMEOUT_TICKS = READY_TIMEOUT_MS * 1000 / TICK_US;
  localparam int unsigned FAST_FLASH_MS       = 100;
  localparam int unsigned FAST_FLASH_TICKS    = FAST_FLASH_MS * 1000 / TICK_US;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFSET    = 8'h00;
  localparam logic [7:0] COMMAND_OFFSET    = 8'h04;
  localparam logic [7:0] SWEEP_OFFSET      = 8'h08;
  localparam logic [7:0] CONFIG_OFFSET     = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET     = 8'h10;
  localparam logic [7:0] ERROR_OFFSET      = 8'h14;
  localparam logic [7:0] INT_STATUS_OFFSET = 8'h18;
  localparam logic [7:0] INT_ENABLE_OFFSET = 8'h1C;
  localparam logic [7:0] INT_CLEAR_OFFSET  = 8'h20;

  // ---------------------------------------------------------------
  // host control bits
  // ---------------------------------------------------------------
  localparam int CTL_WIDTH        = 7;
  localparam int CTL_DRIVE_EN_BIT = 0;
  localparam int CTL_CLEAR_BIT    = 1;
  localparam int CTL_HOME_BIT     = 2;
  localparam int CTL_PROGRAM_BIT  = 3;
  localparam int CTL_LOCAL_BIT    = 4;
  localparam int CTL_JOG_FWD_BIT  = 5;
  localparam int CTL_JOG_REV_BIT  = 6;

  // ---------------------------------------------------------------
  // host command word: type in [7:0], operand in [31:8]
  // ---------------------------------------------------------------
  localparam int         CMD_TYPE_WIDTH   = 8;
  localparam int         CMD_OPER_LSB     = 8;
  localparam int         CMD_OPER_WIDTH   = 24;
  localparam logic [7:0] CMD_NONE         = 8'h00;
  localparam logic [7:0] CMD_VELOCITY     = 8'h01;
  localparam logic [7:0] CMD_POSITION     = 8'h02;

  // ---------------------------------------------------------------
  // configuration, status and interrupt fields
  // ---------------------------------------------------------------
  localparam int          CFG_READY_EN_BIT = 0;
  localparam int          CFG_COMMIT_BIT   = 1;
  localparam logic [31:0] CFG_RSVD_MASK    = 32'hFFFF_FFFC;

  localparam int ST_ERROR_BIT    = 0;
  localparam int ST_ACTIVE_BIT   = 1;
  localparam int ST_DRIVE_ON_BIT = 2;
  localparam int ST_CFG_OK_BIT   = 3;
  localparam int ST_FIRST_BIT    = 4;
  localparam int ST_AMP_OK_BIT   = 5;
  localparam int ST_JOG_ONLY_BIT = 6;

  localparam int INT_WIDTH   = 4;
  localparam int INT_FAULT   = 0;
  localparam int INT_REJECT  = 1;
  localparam int INT_CFG_ERR = 2;
  localparam int INT_SWEEP   = 3;

  // ---------------------------------------------------------------
  // error codes: axis word in [15:0], system word in [31:16]
  // ---------------------------------------------------------------
  localparam logic [15:0] ERR_NONE        = 16'h0000;
  localparam logic [15:0] ERR_DRIVE_READY = 16'h00C0;
  localparam logic [15:0] ERR_STOP_INPUT  = 16'h00C1;
  localparam logic [15:0] ERR_FIRST_SWEEP = 16'h0021;
  localparam logic [15:0] SYS_ERR_CONFIG  = 16'hD001;

  typedef enum logic [2:0] {
    ST_UNCONFIG = 3'b001,
    ST_READY    = 3'b010,
    ST_FAULT    = 3'b100
  } axis_state_e;

endpackage

//--- rtl/tick_divider.sv
// one-cycle enable pulse every CYCLES clocks
// assumes a single hclk domain and CYCLES of at least 2
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned CYCLES = 25000
)(
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);

  localparam int CW = $clog2(CYCLES);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          tick;
  } div_s;

  div_s r;
  div_s n;

  always_comb begin
    n      = r;
    n.tick = 1'b0;
    if (r.count == CW'(CYCLES - 1)) begin
      n.count = '0;
      n.tick  = 1'b1;
    end else begin
      n.count = r.count + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule

//--- verification/axis_interlock_checker.sv
// port-level assertions for the axis interlock
// assumes it is bound into axis_enable_fault_interlock running 4-cycle ticks
`timescale 1ns/1ps
module axis_interlock_checker import axis_interlock_pkg::*; (
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic                      stop_fault,
  input wire logic                      drive_relay,
  input wire logic                      status_led,
  input wire logic                      cfg_ok_led,
  input wire logic                      jog_fwd,
  input wire logic                      jog_rev,
  input wire logic                      home_start,
  input wire logic                      program_start,
  input wire logic                      local_logic_start,
  input wire logic                      velocity_move_start,
  input wire logic                      position_move_start,
  input wire logic [CMD_OPER_WIDTH-1:0] move_operand
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic go;
  logic any;
  assign go  = home_start | program_start | velocity_move_start | position_move_start;
  assign any = go | local_logic_start;
  a_halt_relay_off: assert property (stop_fault [*6] |-> !drive_relay)
    else $error("relay closed during stop fault");
  a_halt_no_motion: assert property (stop_fault [*6] |-> !(any | jog_fwd | jog_rev))
    else $error("motion output during stop fault");
  a_halt_led_flash: assert property ((stop_fault && cfg_ok_led) [*8]
    |-> ##[1:12] $changed(status_led)) else $error("status led not flashing");
  a_unconfig_quiet: assert property (!cfg_ok_led |-> !(drive_relay | any | jog_fwd | jog_rev))
    else $error("output active while unconfigured");
  a_move_needs_drive: assert property (go |-> drive_relay)
    else $error("start pulse without drive enabled");
  a_single_pulse: assert property (any |=> !any)
    else $error("start pulse longer than one cycle");
  a_operand_on_move: assert property ($changed(move_operand) |-> velocity_move_start || position_move_start)
    else $error("operand changed without a move start");
  a_one_move_kind: assert property (!(velocity_move_start && position_move_start))
    else $error("two move kinds started together");
  c_move: cover property (velocity_move_start);
  c_home: cover property (home_start);
  c_halt: cover property ($fell(drive_relay) && stop_fault);
  c_cfg: cover property ($rose(cfg_ok_led));
endmodule
bind axis_enable_fault_interlock axis_interlock_checker u_chk (.hclk, .hresetn, .stop_fault,
  .drive_relay, .status_led, .cfg_ok_led, .jog_fwd, .jog_rev, .home_start, .program_start,
  .local_logic_start, .velocity_move_start, .position_move_start, .move_operand);

//--- verification/amp_model.sv
// servo amplifier model: ready output goes low some cycles after the relay closes
// assumes the bench clock; mode 0 prompt, 1 slow, 2 never ready
`timescale 1ns/1ps
module amp_model (
  input  wire logic       hclk,
  input  wire logic       drive_relay,
  input  wire logic [1:0] mode,
  output logic            amp_ready_n
);
  int unsigned on_cnt = 0;
  always @(posedge hclk) on_cnt <= drive_relay ? on_cnt + 1 : 0;
  // unless mode 2, ready well inside the timeout once the relay is closed, pulled high otherwise
  assign amp_ready_n = !(drive_relay && mode != 2'h2 && on_cnt >= (mode == 2'h0 ? 3 : 14));
endmodule

//--- verification/axis_enable_fault_interlock_bench.sv
// self-checking bench: AHB-Lite host, stop pin and amplifier model around the interlock
// assumes package, design, checker and amp_model are compiled first
`timescale 1ns/1ps
module axis_enable_fault_interlock_bench import axis_interlock_pkg::*; ;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b1;
  logic        hwrite = 1'b0;
  logic        stop_fault = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [1:0]  amp_mode = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd, rdv, pcmd, cw = 32'h0;
  logic [6:0]  pctl;
  wire  [4:0]  st;
  logic [23:0] oper;
  logic        hreadyout, hresp, relay, led, cfg_led, jf, jr, irq, amp_n;
  int          n_fail = 0;
  int          checks_done = 0;

  axis_enable_fault_interlock #(.TICK_CYCLES_P(4), .READY_TIMEOUT_P(5), .FLASH_TICKS_P(2)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata(rd), .amp_ready_n(amp_n), .stop_fault,
    .drive_relay(relay), .status_led(led), .cfg_ok_led(cfg_led), .jog_fwd(jf), .jog_rev(jr),
    .home_start(st[0]), .program_start(st[1]), .local_logic_start(st[2]),
    .velocity_move_start(st[3]), .position_move_start(st[4]), .move_operand(oper), .irq);
  amp_model u_amp (.hclk, .drive_relay(relay), .mode(amp_mode), .amp_ready_n(amp_n));

  initial forever #20 hclk = ~hclk;
  // one nibble per start output: home, program, local, velocity, position
  always @(posedge hclk) for (int i = 0; i < 5; i++) if (st[i] === 1'b1) cw += 32'h1 << (4 * i);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] exp_st(input logic [6:0] c, p, input logic [31:0] m, q,
                                          input logic run);
    logic [6:0] r;
    logic       d, mv;
    r  = c & ~p;
    d  = run && c[CTL_DRIVE_EN_BIT];
    mv = d && m != q;
    return {12'h0, 3'h0, mv && m[7:0] == CMD_POSITION, 3'h0, mv && m[7:0] == CMD_VELOCITY,
            3'h0, run && r[CTL_LOCAL_BIT], 3'h0, d && r[CTL_PROGRAM_BIT], 3'h0, d && r[CTL_HOME_BIT]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = rd;
  endtask

  task automatic chkreg(input string nm, input logic [7:0] a, input logic [31:0] k, e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rdv & k);
    chk("hresp", 32'h0, hresp);
  endtask

  task automatic sweep(input logic [6:0] c, input logic [31:0] m, input logic run);
    logic [31:0] e, b;
    e = exp_st(c, pctl, m, pcmd, run);
    b = cw;
    xfer(1'b1, CONTROL_OFFSET, {25'h0, c});
    xfer(1'b1, COMMAND_OFFSET, m);
    xfer(1'b1, SWEEP_OFFSET, 32'h0);
    repeat (3) @(posedge hclk);
    chk("starts", e, cw - b);
    if (e[19:12] != 8'h0)
      chk("operand", {8'h0, m[31:8]}, {8'h0, oper});
    pctl = c;
    pcmd = m;
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    pctl = 7'h0;
    pcmd = 32'h0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    tally_and_finish;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [6:0]  c;
    logic [31:0] m;
    void'($urandom(32'h3B97));
    do_reset;
    xfer(1'b1, CONFIG_OFFSET, 32'h6);
    sweep(7'h05, {24'h12, CMD_VELOCITY}, 1'b0);
    chk("leds and relay", 32'h0, {led, cfg_led, relay});
    chkreg("system error", ERROR_OFFSET, 32'hFFFF_0000, {SYS_ERR_CONFIG, 16'h0});
    $display("test unconfigured done");
    do_reset;
    xfer(1'b1, CONFIG_OFFSET, 32'h2);
    xfer(1'b1, INT_ENABLE_OFFSET, 32'h3);
    sweep(7'h1D, {24'h34, CMD_POSITION}, 1'b0);
    chkreg("first sweep error", ERROR_OFFSET, 32'hFFFF, ERR_FIRST_SWEEP);
    chk("irq and relay", 32'h3, {irq, relay});
    xfer(1'b1, INT_CLEAR_OFFSET, 32'hF);
    chkreg("int cleared", INT_STATUS_OFFSET, 32'hF, 32'h0);
    chk("irq cleared", 32'h0, irq);
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
    chkreg("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
    sweep(7'h03, 32'h0, 1'b1);
    chkreg("warning cleared", STATUS_OFFSET, 32'h7, 32'h6);
    $display("test first sweep done");
    for (int i = 0; i < 24; i++) begin
      c = 7'($urandom) & 7'h7D;
      m = {24'($urandom), 8'($urandom_range(2, 0))};
      sweep(c, m, 1'b1);
      chk("relay and jog", {c[6:5], c[0]}, {jr, jf, relay});
    end
    sweep(c, m, 1'b1);
    $display("test random sweeps done");
    sweep(7'h01, 32'h0, 1'b1);
    stop_fault <= 1'b1;
    repeat (30) @(posedge hclk);
    chkreg("halt status", STATUS_OFFSET, 32'h7, 32'h1);
    chkreg("halt error", ERROR_OFFSET, 32'hFFFF, ERR_STOP_INPUT);
    chk("halt irq", 32'h1, irq);
    sweep(7'h3D, {24'h56, CMD_VELOCITY}, 1'b0);
    chk("halt outputs", 32'h0, {jr, jf, relay});
    sweep(7'h03, 32'h0, 1'b0);
    chk("clear with cause", 32'h0, relay);
    xfer(1'b1, INT_ENABLE_OFFSET, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq masked", 32'h0, irq);
    stop_fault <= 1'b0;
    sweep(7'h01, 32'h0, 1'b0);
    sweep(7'h03, 32'h0, 1'b0);
    chk("restored", 32'h3, {led, relay});
    stop_fault <= 1'b1;
    repeat (8) @(posedge hclk);
    stop_fault <= 1'b0;
    sweep(7'h03, 32'h0, 1'b0);
    chk("held clear", 32'h0, relay);
    sweep(7'h01, 32'h0, 1'b0);
    sweep(7'h03, 32'h0, 1'b0);
    chk("clear edge", 32'h1, relay);
    $display("test halting fault done");
    do_reset;
    xfer(1'b1, CONFIG_OFFSET, 32'h3);
    amp_mode <= 2'h1;
    sweep(7'h01, 32'h0, 1'b1);
    repeat (60) @(posedge hclk);
    chkreg("amp ready", STATUS_OFFSET, 32'h27, 32'h26);
    amp_mode <= 2'h2;
    repeat (6) @(posedge hclk);
    chk("amp lost", 32'h0, relay);
    chkreg("amp error", ERROR_OFFSET, 32'hFFFF, ERR_DRIVE_READY);
    sweep(7'h03, 32'h0, 1'b0);
    chk("relay reclosed", 32'h1, relay);
    repeat (60) @(posedge hclk);
    chk("amp timeout", 32'h0, relay);
    chkreg("timeout error", ERROR_OFFSET, 32'hFFFF, ERR_DRIVE_READY);
    $display("test amplifier ready done");
    tally_and_finish;
  end
endmodule
